// ===== rtl/limit_switch_cfg.svh
// Offsets, field positions and reset values of the limit-switch stop logic.
// Assumes it is included by bare name by the package users of this block.
`ifndef LIMIT_SWITCH_CFG_SVH
`define LIMIT_SWITCH_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (word addresses on the register port)
// ----------------------------------------------------------------------------
`define OFS_LIMIT_SWITCH_CONFIG   8'h01
`define OFS_EVENT_FLAGS           8'h0E
`define OFS_STATUS_FLAGS          8'h0F
`define OFS_STOP_DECELERATION     8'h2C
`define OFS_SOFT_LIMIT_LOW        8'h33
`define OFS_SOFT_LIMIT_HIGH       8'h34
`define OFS_POSITION_LATCH        8'h36

// ----------------------------------------------------------------------------
// Fields of limit_switch_config
// ----------------------------------------------------------------------------
`define CFG_LEFT_EN               0
`define CFG_RIGHT_EN              1
`define CFG_LEFT_POL              2
`define CFG_RIGHT_POL             3
`define CFG_SWAP_DIR              4
`define CFG_SOFT_STOP_EN          5
`define CFG_SOFT_MODE_LO          6
`define CFG_SOFT_MODE_HI          7
`define CFG_LATCH_INACT_L         8
`define CFG_LATCH_ACT_L           9
`define CFG_LATCH_INACT_R         10
`define CFG_LATCH_ACT_R           11
`define CFG_SOFT_LOW_EN           12
`define CFG_SOFT_HIGH_EN          13
`define CFG_USED_MSB              13

// ----------------------------------------------------------------------------
// Bit positions shared by event_flags and status_flags
// ----------------------------------------------------------------------------
`define FLG_LEFT                  0
`define FLG_RIGHT                 1
`define FLG_SOFT_LOW              2
`define FLG_SOFT_HIGH             3
`define FLG_LATCH_DONE            4
`define FLG_MSB                   4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CONFIG                14'h0000
`define RST_WORD                  32'h00000000
`define RST_FLAGS                 5'h00

`endif

// ===== rtl/limit_switch_pkg.sv
// Types shared by the limit-switch stop logic.
// Assumes nothing of its surroundings; users write limit_switch_pkg::name.
package limit_switch_pkg;

  // Signed microstep position or velocity word.
  typedef logic signed [31:0] word_t;

  // Stop type selected for the soft limits.
  typedef enum logic [1:0] {
    SOFT_MODE_NONE   = 2'h0,
    SOFT_MODE_HARD   = 2'h1,
    SOFT_MODE_LINEAR = 2'h2,
    SOFT_MODE_RSVD   = 2'h3
  } soft_mode_e;

endpackage

// ===== rtl/limit_sync2.sv
// Two-stage synchroniser for asynchronous level inputs.
// Assumes the reset given is already synchronous to clk on release.
`timescale 1ns/1ps

module limit_sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // The first stage is read only by the second stage, to contain metastability.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ===== rtl/limit_switch_stop_logic.sv
// Limit-switch stop logic of a stepper ramp controller: hard limit inputs,
// soft position limits, stop requests, sticky events and direction locks.
// Assumes the ramp generator supplies actual velocity and position on mclk
// and obeys the stop and block outputs; registers sit on a simple word port.
//
// Functional notes
// R1 - Enabled active left limit, negative velocity stops ramp.
// R2 - Enabled active right limit, positive velocity stops ramp.
// R3 - Software sets polarity, then enable, before motion.
// R4 - Soft-stop enable clear: hardware limit zeroes velocity.
// R5 - Soft-stop enable set: linear stop using stop decel.
// R6 - Software programs stop decel above other decelerations.
// R7 - Status flag follows enabled active hardware limit.
// R8 - Matching event bit stays until software clears.
// R9 - After zero velocity, stopped direction is locked.
// R10 - Lock released: switch idle and event cleared.
// R11 - Latch position on selected limit input edges.
// R12 - Swap bit exchanges left and right inputs.
// R13 - Lower soft limit stops at position below threshold; the code also stops at a position equal to it.
// R14 - Upper soft limit stops at position above threshold; the code also stops at a position equal to it.
// R15 - Soft mode 01 zeroes velocity immediately.
// R16 - Soft mode 10 decelerates linearly with stop decel.
// R17 - Soft limits set status, event and lock alike.
// R18 - Soft lock released: within limit and event cleared.
// R19 - Swap bit leaves soft limit roles unchanged.
// R20 - Limit inputs synchronised before any comparison.
// R21 - Soft limit positions are signed 32-bit compares.
// R22 - Position latch is a signed 32-bit register.
`timescale 1ns/1ps
`include "limit_switch_cfg.svh"

module limit_switch_stop_logic (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Limit switch pins
  input  wire logic        left_limit_input,
  input  wire logic        right_limit_input,
  // Ramp generator state
  input  wire logic [31:0] actual_velocity,
  input  wire logic [31:0] actual_position,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // Stop commands to the ramp generator
  output logic             hard_stop,
  output logic             linear_stop,
  output logic      [31:0] stop_decel_value,
  // Direction locks to the ramp generator
  output logic             block_negative,
  output logic             block_positive
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_meta_b_ff;
  logic rst_sync_b_ff;
  logic rst_int_b;

  // Reset asserts at once and releases after two edges, so no flop leaves
  // reset on a different edge than its neighbours.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b_ff <= 1'b0;
      rst_sync_b_ff <= 1'b0;
    end else begin
      rst_meta_b_ff <= 1'b1;
      rst_sync_b_ff <= rst_meta_b_ff;
    end
  end

  assign rst_int_b = rst_sync_b_ff;

  // --------------------------------------------------------------------------
  // Input synchronisation and swapping
  // --------------------------------------------------------------------------
  logic [1:0] pins_sync;
  logic       left_lvl;
  logic       right_lvl;
  logic       left_lvl_d_ff;
  logic       right_lvl_d_ff;

  limit_sync2 #(
    .WIDTH    (2)
  ) u_pin_sync (
    .clk      (mclk),
    .rst_b    (rst_int_b),
    .async_in ({right_limit_input, left_limit_input}), // R20
    .sync_out (pins_sync)
  );

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [`CFG_USED_MSB:0] config_ff;
  logic [`CFG_USED_MSB:0] nxt_config;
  logic [31:0]            stop_decel_ff;
  logic [31:0]            nxt_stop_decel;
  logic signed [31:0]     soft_low_ff;
  logic signed [31:0]     nxt_soft_low;
  logic signed [31:0]     soft_high_ff;
  logic signed [31:0]     nxt_soft_high;
  logic signed [31:0]     latch_pos_ff;
  logic signed [31:0]     nxt_latch_pos;
  logic [`FLG_MSB:0]      events_ff;
  logic [`FLG_MSB:0]      nxt_events;
  logic [`FLG_MSB:0]      status_ff;
  logic [`FLG_MSB:0]      nxt_status;
  logic [31:0]            rdata_ff;
  logic [31:0]            nxt_rdata;
  logic                   hard_stop_ff;
  logic                   linear_stop_ff;
  logic                   lock_neg_ff;
  logic                   lock_pos_ff;

  // Swap picks which synchronised pin plays the left and right roles.
  assign left_lvl  = config_ff[`CFG_SWAP_DIR] ? pins_sync[1] : pins_sync[0]; // R12
  assign right_lvl = config_ff[`CFG_SWAP_DIR] ? pins_sync[0] : pins_sync[1]; // R12

  // Previous levels for edge detection; they read the second sync stage only.
  always_ff @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      left_lvl_d_ff  <= 1'b0;
      right_lvl_d_ff <= 1'b0;
    end else begin
      left_lvl_d_ff  <= left_lvl;
      right_lvl_d_ff <= right_lvl;
    end
  end

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  wire sel_config = (reg_addr == `OFS_LIMIT_SWITCH_CONFIG);
  wire sel_events = (reg_addr == `OFS_EVENT_FLAGS);
  wire sel_status = (reg_addr == `OFS_STATUS_FLAGS);
  wire sel_decel  = (reg_addr == `OFS_STOP_DECELERATION);
  wire sel_low    = (reg_addr == `OFS_SOFT_LIMIT_LOW);
  wire sel_high   = (reg_addr == `OFS_SOFT_LIMIT_HIGH);
  wire sel_latch  = (reg_addr == `OFS_POSITION_LATCH);

  wire wr_config  = reg_wr & sel_config;
  wire wr_decel   = reg_wr & sel_decel;
  wire wr_low     = reg_wr & sel_low;
  wire wr_high    = reg_wr & sel_high;
  wire wr_latch   = reg_wr & sel_latch;
  // Any read or write of the event register clears every event bit not raised again in that cycle.
  wire clr_events = (reg_wr | reg_rd) & sel_events; // R10 R18

  // --------------------------------------------------------------------------
  // Configuration fields
  // --------------------------------------------------------------------------
  wire left_en        = config_ff[`CFG_LEFT_EN];
  wire right_en       = config_ff[`CFG_RIGHT_EN];
  wire left_pol       = config_ff[`CFG_LEFT_POL];
  wire right_pol      = config_ff[`CFG_RIGHT_POL];
  wire soft_stop_en   = config_ff[`CFG_SOFT_STOP_EN];
  wire soft_low_en    = config_ff[`CFG_SOFT_LOW_EN];
  wire soft_high_en   = config_ff[`CFG_SOFT_HIGH_EN];
  wire latch_inact_l  = config_ff[`CFG_LATCH_INACT_L];
  wire latch_act_l    = config_ff[`CFG_LATCH_ACT_L];
  wire latch_inact_r  = config_ff[`CFG_LATCH_INACT_R];
  wire latch_act_r    = config_ff[`CFG_LATCH_ACT_R];

  limit_switch_pkg::soft_mode_e soft_mode;
  assign soft_mode = limit_switch_pkg::soft_mode_e'(
    config_ff[`CFG_SOFT_MODE_HI:`CFG_SOFT_MODE_LO]);

  // --------------------------------------------------------------------------
  // Limit detection
  // --------------------------------------------------------------------------
  limit_switch_pkg::word_t vel_s;
  limit_switch_pkg::word_t pos_s;
  assign vel_s = limit_switch_pkg::word_t'(actual_velocity);
  assign pos_s = limit_switch_pkg::word_t'(actual_position);

  wire vel_neg  = vel_s < 0;
  wire vel_pos  = vel_s > 0;
  wire vel_zero = (actual_velocity == 32'h00000000);

  // A pin is active when its level equals its polarity bit.
  wire left_active  = left_en & (left_lvl == left_pol);     // R7
  wire right_active = right_en & (right_lvl == right_pol);  // R7

  // Soft limits keep their roles regardless of the swap bit.
  wire low_active  = soft_low_en & (pos_s <= soft_low_ff);    // R13 R19 R21
  wire high_active = soft_high_en & (pos_s >= soft_high_ff);  // R14 R19 R21

  // Hardware limits stop only when moving toward them.
  wire hw_req   = (left_active & vel_neg) | (right_active & vel_pos); // R1 R2
  // Soft limits likewise act only on travel into the limit.
  wire soft_req = (low_active & vel_neg) | (high_active & vel_pos);   // R13 R14

  // --------------------------------------------------------------------------
  // Stop type selection
  // --------------------------------------------------------------------------
  // A hard stop wins over a linear one when both are requested, since the
  // velocity is forced to zero anyway.
  wire hw_hard     = hw_req & ~soft_stop_en;                                 // R4
  wire hw_linear   = hw_req & soft_stop_en;                                  // R5
  wire soft_hard   = soft_req & (soft_mode == limit_switch_pkg::SOFT_MODE_HARD);   // R15
  wire soft_linear = soft_req & (soft_mode == limit_switch_pkg::SOFT_MODE_LINEAR); // R16
  wire nxt_hard    = hw_hard | soft_hard;
  wire nxt_linear  = (hw_linear | soft_linear) & ~nxt_hard;

  // --------------------------------------------------------------------------
  // Status, events and direction locks
  // --------------------------------------------------------------------------
  wire left_edge   = left_lvl ^ left_lvl_d_ff;
  wire right_edge  = right_lvl ^ right_lvl_d_ff;
  // Entering the active level means the new level equals the polarity.
  wire left_to_act = left_edge & (left_lvl == left_pol);
  wire left_to_in  = left_edge & (left_lvl != left_pol);
  wire right_to_act = right_edge & (right_lvl == right_pol);
  wire right_to_in  = right_edge & (right_lvl != right_pol);

  wire latch_hit = (latch_act_l & left_to_act) | (latch_inact_l & left_to_in) |
                   (latch_act_r & right_to_act) | (latch_inact_r & right_to_in); // R11

  wire [`FLG_MSB:0] raise;
  assign raise = {latch_hit, high_active, low_active, right_active, left_active};

  // Status follows live conditions; the latch bit has no level meaning.
  always_comb begin
    nxt_status = raise;                       // R7 R17
    nxt_status[`FLG_LATCH_DONE] = 1'b0;
  end

  // Events stay set until cleared; a condition present in the clearing cycle
  // keeps its bit, so a still-active limit cannot be cleared away.
  always_comb begin
    nxt_events = (clr_events ? {(`FLG_MSB + 1){1'b0}} : events_ff) | raise; // R8 R17
  end

  // Locks engage at zero velocity while an event for that side stands, and
  // fall away only when the event is gone.
  wire ev_neg_next = nxt_events[`FLG_LEFT] | nxt_events[`FLG_SOFT_LOW];
  wire ev_pos_next = nxt_events[`FLG_RIGHT] | nxt_events[`FLG_SOFT_HIGH];
  wire nxt_lock_neg = ev_neg_next & (lock_neg_ff | vel_zero); // R9 R10 R17 R18
  wire nxt_lock_pos = ev_pos_next & (lock_pos_ff | vel_zero); // R9 R10 R17 R18

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // Configuration, deceleration and soft limit words store written data.
  always_comb begin
    nxt_config     = wr_config ? reg_wdata[`CFG_USED_MSB:0] : config_ff;
    nxt_stop_decel = wr_decel  ? reg_wdata : stop_decel_ff;
    nxt_soft_low   = wr_low    ? reg_wdata : soft_low_ff;
    nxt_soft_high  = wr_high   ? reg_wdata : soft_high_ff;
  end

  // A hardware capture beats a software write in the same cycle.
  always_comb begin
    if (latch_hit) begin
      nxt_latch_pos = pos_s;                  // R11 R22
    end else if (wr_latch) begin
      nxt_latch_pos = reg_wdata;
    end else begin
      nxt_latch_pos = latch_pos_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Read data is held in a flop; unmapped offsets return zero.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      nxt_rdata = 32'h00000000;
      if (sel_config) begin
        nxt_rdata[`CFG_USED_MSB:0] = config_ff;
      end else if (sel_events) begin
        nxt_rdata[`FLG_MSB:0] = events_ff;
      end else if (sel_status) begin
        nxt_rdata[`FLG_MSB:0] = status_ff;
      end else if (sel_decel) begin
        nxt_rdata = stop_decel_ff;
      end else if (sel_low) begin
        nxt_rdata = soft_low_ff;
      end else if (sel_high) begin
        nxt_rdata = soft_high_ff;
      end else if (sel_latch) begin
        nxt_rdata = latch_pos_ff;
      end
    end
  end

  // --------------------------------------------------------------------------
  // State flops
  // --------------------------------------------------------------------------
  // Configuration holds its reset value until software writes it.
  always_ff @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      config_ff     <= `RST_CONFIG;
      stop_decel_ff <= `RST_WORD;
      soft_low_ff   <= `RST_WORD;
      soft_high_ff  <= `RST_WORD;
      latch_pos_ff  <= `RST_WORD;
    end else begin
      config_ff     <= nxt_config;
      stop_decel_ff <= nxt_stop_decel;
      soft_low_ff   <= nxt_soft_low;
      soft_high_ff  <= nxt_soft_high;
      latch_pos_ff  <= nxt_latch_pos;
    end
  end

  // Flags, locks, stop commands and read data.
  always_ff @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      events_ff      <= `RST_FLAGS;
      status_ff      <= `RST_FLAGS;
      lock_neg_ff    <= 1'b0;
      lock_pos_ff    <= 1'b0;
      hard_stop_ff   <= 1'b0;
      linear_stop_ff <= 1'b0;
      rdata_ff       <= `RST_WORD;
    end else begin
      events_ff      <= nxt_events;
      status_ff      <= nxt_status;
      lock_neg_ff    <= nxt_lock_neg;
      lock_pos_ff    <= nxt_lock_pos;
      hard_stop_ff   <= nxt_hard;
      linear_stop_ff <= nxt_linear;
      rdata_ff       <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // The stop deceleration is passed through; the stop velocity parameter of
  // the ramp is not involved in a limit stop.
  assign stop_decel_value = stop_decel_ff;                 // R5 R16
  assign hard_stop        = hard_stop_ff;                  // R4 R15
  assign linear_stop      = linear_stop_ff;                // R5 R16
  assign block_negative   = lock_neg_ff;                   // R9
  assign block_positive   = lock_pos_ff;                   // R9
  assign reg_rdata        = rdata_ff;

endmodule

// ===== test/limit_switch_checker.sv
// Port-level assertions for the limit-switch stop logic.
// Assumes one clock, mclk, and rst_b as its asynchronous reset.
`timescale 1ns/1ps
module limit_switch_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // Pins and ramp state
  input wire logic        left_limit_input,
  input wire logic        right_limit_input,
  input wire logic [31:0] actual_velocity,
  input wire logic [31:0] actual_position,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Commands to the ramp
  input wire logic        hard_stop,
  input wire logic        linear_stop,
  input wire logic [31:0] stop_decel_value,
  input wire logic        block_negative,
  input wire logic        block_positive
);
  // ----------------------------------------------------------------
  // Shadow of the configuration word
  // ----------------------------------------------------------------
  logic [13:0] cfg_ff;
  // Inputs are taken after the swap, so a swapped pin is judged by its new side.
  wire l_pin  = cfg_ff[4] ? right_limit_input : left_limit_input;
  wire r_pin  = cfg_ff[4] ? left_limit_input : right_limit_input;
  wire no_sft = cfg_ff[13:12] == 2'h0;
  wire l_hard = cfg_ff[0] && (l_pin == cfg_ff[2]) && !cfg_ff[5] && no_sft;
  wire r_lin  = cfg_ff[1] && (r_pin == cfg_ff[3]) && cfg_ff[5] && no_sft;
  wire ev_clr = (reg_rd || reg_wr) && reg_addr == 8'h0E;

  // Tracks writes the same way the design applies them.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= 14'h0000;
    end else if (reg_wr && reg_addr == 8'h01) begin
      cfg_ff <= reg_wdata[13:0];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_left_hard: assert property (
    l_hard [*3] ##0 $signed(actual_velocity) < 0 |=> hard_stop && !linear_stop)
    else $error("left limit did not give a hard stop");
  a_right_linear: assert property (
    r_lin [*3] ##0 $signed(actual_velocity) > 0 |=> linear_stop && !hard_stop)
    else $error("right limit did not give a linear stop");
  a_stop_moving: assert property (
    hard_stop || linear_stop |-> $past(actual_velocity) != 32'h00000000)
    else $error("stop requested while standing still");
  a_hard_wins: assert property (
    !(hard_stop && linear_stop))
    else $error("hard and linear stop together");
  a_decel_copy: assert property (
    reg_wr && reg_addr == 8'h2C ##1 !(reg_wr && reg_addr == 8'h2C)
    |=> stop_decel_value == $past(reg_wdata, 2))
    else $error("stop deceleration not forwarded");
  a_lock_zero: assert property (
    $rose(block_negative) || $rose(block_positive) |-> $past(actual_velocity) == 32'h00000000)
    else $error("lock engaged while moving");
  a_lock_release: assert property (
    $fell(block_negative) |-> $past(ev_clr) || $past(ev_clr, 2))
    else $error("lock released without event clear");
  a_cfg_readback: assert property (
    reg_rd && !reg_wr && reg_addr == 8'h01 |=> reg_rdata == {18'h00000, cfg_ff})
    else $error("configuration read back wrong");
endmodule

bind limit_switch_stop_logic limit_switch_checker limit_switch_checker_i (
  .mclk, .rst_b, .left_limit_input, .right_limit_input, .actual_velocity,
  .actual_position, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .hard_stop, .linear_stop, .stop_decel_value, .block_negative, .block_positive
);

// ===== test/limit_switch_model.sv
// Two mechanical limit switches with pull resistors.
// Assumes the bench says which switch is closed and its active level.
`timescale 1ns/1ps
module limit_switch_model (
  // Mechanical state
  input  wire logic pressed_l,
  input  wire logic pressed_r,
  input  wire logic active_l,
  input  wire logic active_r,
  // Pin levels
  output logic      left_pin,
  output logic      right_pin
);
  // An open switch leaves its line at the pull level, the inactive one.
  assign left_pin  = pressed_l ? active_l : !active_l;
  assign right_pin = pressed_r ? active_r : !active_r;
endmodule

// ===== test/testbench.sv
// Self-checking bench for the limit-switch stop logic.
// Assumes inputs are taken on rising mclk; the bench drives on falling mclk.
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pressed_l = 1'b0;
  logic        pressed_r = 1'b0;
  logic        active_l = 1'b1;
  logic        active_r = 1'b1;
  logic        left_pin, right_pin, hard_stop, linear_stop, block_negative, block_positive;
  logic [31:0] vel = 32'h00000000;
  logic [31:0] pos = 32'h00000000;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_seen = 1'b0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata, stop_decel_value, rnd, dval;
  logic [31:0] exp_q[$];
  string       nm_q[$];
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;

  limit_switch_model limit_switch_model_i (.pressed_l, .pressed_r, .active_l, .active_r,
    .left_pin, .right_pin);
  limit_switch_stop_logic limit_switch_stop_logic_i (.mclk, .rst_b,
    .left_limit_input(left_pin), .right_limit_input(right_pin), .actual_velocity(vel),
    .actual_position(pos), .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .hard_stop,
    .linear_stop, .stop_decel_value, .block_negative, .block_positive);

  // ----------------------------------------------------------------
  // Clock, watchdog, shared tasks
  // ----------------------------------------------------------------
  always #20 mclk = ~mclk;

  // A hang is cut short here; the ceiling is well above the sequence length.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      summarize();
    end
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  // The expected word is noted now and compared when the answer appears.
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    nm_q.push_back($sformatf("reg_%h", a));
    @(negedge mclk);
    reg_rd = 1'b0;
  endtask

  task automatic outs(logic [3:0] e);
    chk("stop_lock", {28'h0000000, hard_stop, linear_stop, block_negative, block_positive},
      {28'h0000000, e});
  endtask

  task automatic wt(int n);
    repeat (n) @(negedge mclk);
  endtask

  // Read data stands one cycle after the strobe, so it is judged a half cycle later.
  always @(posedge mclk) rd_seen <= reg_rd;
  always @(negedge mclk) begin
    if (rd_seen === 1'b1) begin
      chk(nm_q.pop_front(), reg_rdata, exp_q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rnd = 32'hd9c7;
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    wt(4);
    rd(8'h01, 32'h0);
    rd(8'h0E, 32'h0);
    rd(8'h0F, 32'h0);
    rd(8'h2C, 32'h0);
    rd(8'h33, 32'h0);
    rd(8'h34, 32'h0);
    rd(8'h36, 32'h0);
    rd(8'h50, 32'h0);
    // Left hard stop, lock at standstill, release after clear.
    wr(8'h01, 32'h00000004);
    wr(8'h01, 32'h00000005);
    rd(8'h01, 32'h00000005);
    vel = 32'hFFFFFFFB;
    pressed_l = 1'b1;
    wt(4);
    outs(4'b1000);
    rd(8'h0F, 32'h1);
    rd(8'h0E, 32'h1);
    vel = 32'h0;
    wt(2);
    outs(4'b0010);
    pressed_l = 1'b0;
    wt(4);
    rd(8'h0F, 32'h0);
    outs(4'b0010);
    rd(8'h0E, 32'h1);
    wt(3);
    outs(4'b0000);
    rd(8'h0E, 32'h0);
    // Swapped inputs: left pin acts as the active-low right limit, linear stop.
    rnd = lfsr(rnd);
    dval = rnd | 32'h00100000;
    wr(8'h2C, dval);
    active_l = 1'b0;
    wr(8'h01, 32'h00000032);
    vel = 32'h00000007;
    pressed_l = 1'b1;
    wt(4);
    outs(4'b0100);
    chk("stop_decel_value", stop_decel_value, dval);
    rd(8'h0F, 32'h2);
    pressed_l = 1'b0;
    // Let the released pin pass the synchroniser, or the clear is refused.
    wt(3);
    wr(8'h0E, 32'h0);
    // Position latch on entering and on leaving the active level.
    active_l = 1'b1;
    vel = 32'h0;
    wr(8'h01, 32'h00000204);
    rnd = lfsr(rnd);
    pos = rnd;
    pressed_l = 1'b1;
    wt(4);
    rd(8'h36, rnd);
    rd(8'h0E, 32'h10);
    wr(8'h01, 32'h00000104);
    rnd = lfsr(rnd);
    pos = rnd;
    pressed_l = 1'b0;
    wt(4);
    rd(8'h36, rnd);
    // Upper soft limit at its boundary, every stop mode, swap set.
    wr(8'h33, 32'hFFFFFF9C);
    wr(8'h34, 32'h000000C8);
    pos = 32'h000000C8;
    vel = 32'h00000003;
    for (int m = 0; m < 4; m++) begin
      wr(8'h01, 32'h00002010 | (m << 6));
      wt(3);
      outs({m == 1, m == 2, 2'b00});
    end
    rd(8'h0F, 32'h8);
    vel = 32'h0;
    wt(2);
    outs(4'b0001);
    pos = 32'h0;
    wr(8'h0E, 32'h0);
    wt(3);
    outs(4'b0000);
    // Lower soft limit: hit at equality, free one step inside.
    wr(8'h01, 32'h00001040);
    pos = 32'hFFFFFF9C;
    vel = 32'hFFFFFFFD;
    wt(3);
    outs(4'b1000);
    rd(8'h0F, 32'h4);
    pos = 32'hFFFFFF9D;
    wt(3);
    outs(4'b0000);
    // Right pin unswapped, active high, hard stop toward positive.
    wr(8'h01, 32'h0000000A);
    vel = 32'h00000005;
    pressed_r = 1'b1;
    wt(4);
    outs(4'b1000);
    rd(8'h0F, 32'h2);
    wt(2);
    summarize();
  end
endmodule
